// [hw/ssp_pkg.sv]
// Purpose: Shared constants and types for the serial port pin role block
// Assumes: 25 MHz system clock, APB register access with 32-bit data
// Notes:   Register offsets are byte addresses, one aligned word each
package ssp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 40;
  localparam int SCK_HALF_MIN_NS = 120;
  localparam int SCK_HALF_CYC    = (SCK_HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W           = 4;
  localparam logic [DIV_W-1:0] SCK_HALF_LAST = DIV_W'(SCK_HALF_CYC - 1);

  // ****************************************
  // Pins
  // ****************************************
  localparam int NPINS     = 6;
  localparam int PIN_CTRL0 = 0;
  localparam int PIN_CTRL1 = 1;
  localparam int PIN_CTRL2 = 2;
  localparam int PIN_SCK   = 3;
  localparam int PIN_RX    = 4;
  localparam int PIN_TX    = 5;

  // ****************************************
  // Registers
  // ****************************************
  localparam int AW = 8;
  localparam logic [AW-1:0] OFS_DIR      = 8'h00;
  localparam logic [AW-1:0] OFS_CTRL     = 8'h04;
  localparam logic [AW-1:0] OFS_MODE     = 8'h08;
  localparam logic [AW-1:0] OFS_GPIO_OUT = 8'h0c;
  localparam logic [AW-1:0] OFS_GPIO_IN  = 8'h10;
  localparam logic [AW-1:0] OFS_TXDATA   = 8'h14;
  localparam logic [AW-1:0] OFS_RXDATA   = 8'h18;
  localparam logic [AW-1:0] OFS_STATUS   = 8'h1c;

  localparam int MODE_W      = 11;
  localparam int M_ASYNC     = 0;
  localparam int M_FLAG0_SEL = 1;
  localparam int M_FLAG1_SEL = 2;
  localparam int M_SCK_OUT   = 3;
  localparam int M_FS_OUT    = 4;
  localparam int M_RXCLK_OUT = 5;
  localparam int M_RXFS_OUT  = 6;
  localparam int M_FLAG0     = 7;
  localparam int M_FLAG1     = 8;
  localparam int M_STOP      = 9;
  localparam int M_WAIT      = 10;

  localparam logic [NPINS-1:0]  DIR_RST  = 6'h00;
  localparam logic [NPINS-1:0]  CTRL_RST = 6'h00;
  localparam logic [NPINS-1:0]  GOUT_RST = 6'h00;
  localparam logic [MODE_W-1:0] MODE_RST = 11'h000;

  localparam int ST_TX_BUSY    = 0;
  localparam int ST_RX_VALID   = 1;
  localparam int ST_FIFO_FULL  = 2;
  localparam int ST_FIFO_EMPTY = 3;

  // ****************************************
  // Data path
  // ****************************************
  localparam int WORD_W     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W      = 3;
  localparam logic [CNT_W-1:0] BIT_LAST = 3'h7;

  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;

endpackage

// [hw/ssp_sync2.sv]
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are asynchronous to CLK
// Notes:   First stage feeds only the second stage
module ssp_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] din,
  output wire logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t st;
  sync_t next_st;

  always_comb
  begin
    next_st        = st;
    next_st.meta   = din;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign dout = st.stable;

endmodule

// [hw/ssp_fifo.sv]
// Purpose: Word FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   in_ready low when full, out_valid low when empty
module ssp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output wire logic             out_valid,
  input  wire logic             out_ready,
  output wire logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 count;
  } fifo_t;

  fifo_t st;
  fifo_t next_st;
  logic  push;
  logic  pop;

  assign in_ready  = (st.count != (PW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd];

  always_comb
  begin
    next_st = st;
    push    = in_valid && in_ready;
    pop     = out_ready && out_valid;
    if (push)
    begin
      next_st.mem[st.wr] = in_data;
      next_st.wr         = PW'((st.wr == PW'(DEPTH - 1)) ? 0 : st.wr + 1'b1);
    end
    if (pop)
      next_st.rd = PW'((st.rd == PW'(DEPTH - 1)) ? 0 : st.rd + 1'b1);
    if (push && !pop)
      next_st.count = st.count + 1'b1;
    else if (pop && !push)
      next_st.count = st.count - 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

endmodule

// [hw/ssp_pin_roles.sv]
// Purpose: Pin function, direction and level control for the second serial port
// Assumes: Pins arrive asynchronous to CLK; APB slave for all settings
// Notes:   Output enables are active low; stop mode freezes pins and input capture
//
// Summary of operation
// - Reset leaves all six pins general inputs
// - General pin direction follows direction register
// - Control bit selects serial function per pin
// - Async: control pin zero is receive clock
// - Sync: pin zero is transmitter one or flag
// - Async: control pin one is receive frame sync
// - Sync: pin one is transmitter two or flag
// - Pin two carries frame sync by mode
// - Pin two drives internal or accepts external sync
// - Bit clock pin clocks transmitter, and receiver in sync mode
// - Receive pin is input, bits shifted in
// - Transmit pin drives shifted bits while busy
// - Stop state ignores inputs, holds output levels
// - Wait state leaves every pin unchanged
//
// Implementation choices: the APB register port and the register offsets.
module ssp_pin_roles
  import ssp_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             ARST_N,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [AW-1:0]    PADDR,
  input  wire logic [31:0]      PWDATA,
  output wire logic [31:0]      PRDATA,
  output wire logic             PREADY,
  output wire logic             PSLVERR,
  input  wire logic [NPINS-1:0] PORT_IN,
  output wire logic [NPINS-1:0] PORT_OUT,
  output wire logic [NPINS-1:0] PORT_OE_N
);

  typedef struct packed {
    logic [NPINS-1:0]  dir;
    logic [NPINS-1:0]  ctrl;
    logic [NPINS-1:0]  gpio_out;
    logic [NPINS-1:0]  gpio_in;
    logic [NPINS-1:0]  port_out;
    logic [NPINS-1:0]  port_oe_n;
    logic [MODE_W-1:0] mode;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic [DIV_W-1:0]  div;
    logic              sck_gen;
    logic              fs_gen;
    logic              txclk_prev;
    logic              rxclk_prev;
    tx_state_t         tx_state;
    logic [WORD_W-1:0] txsh;
    logic [CNT_W-1:0]  txcnt;
    logic [WORD_W-1:0] rxsh;
    logic [WORD_W-1:0] rxword;
    logic [CNT_W-1:0]  rxcnt;
    logic              rx_act;
    logic              rx_valid;
  } state_t;

  localparam state_t ST_RST = '{
    dir: DIR_RST, ctrl: CTRL_RST, gpio_out: GOUT_RST, gpio_in: '0, port_out: '0,
    port_oe_n: '1, mode: MODE_RST, pready: 1'b0, pslverr: 1'b0, prdata: '0,
    div: '0, sck_gen: 1'b0, fs_gen: 1'b0, txclk_prev: 1'b0, rxclk_prev: 1'b0,
    tx_state: TX_IDLE, txsh: '0, txcnt: '0, rxsh: '0, rxword: '0, rxcnt: '0,
    rx_act: 1'b0, rx_valid: 1'b0};

  state_t            st;
  state_t            next_st;
  logic [NPINS-1:0]  pin_s;
  logic              fifo_push;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic [WORD_W-1:0] fifo_out_data;
  logic              tx_clk;
  logic              tx_fs;
  logic              rx_clk;
  logic              rx_fs;
  logic              tx_bit;
  logic              async_m;
  logic              stop_m;
  logic [NPINS-1:0]  s_out;
  logic [NPINS-1:0]  s_oe_n;
  logic              acc;
  logic              tx_stall;

  function automatic logic edge_of(input logic from_lvl, input logic to_lvl,
                                   input logic prev, input logic cur);
    edge_of = (prev == from_lvl) && (cur == to_lvl);
  endfunction

  function automatic logic is_mapped(input logic [AW-1:0] a);
    is_mapped = (a == OFS_DIR) || (a == OFS_CTRL) || (a == OFS_MODE) ||
                (a == OFS_GPIO_OUT) || (a == OFS_GPIO_IN) || (a == OFS_TXDATA) ||
                (a == OFS_RXDATA) || (a == OFS_STATUS);
  endfunction

  // ****************************************
  // Pin input synchroniser
  // ****************************************
  ssp_sync2 #(
    .WIDTH (NPINS)
  ) u_sync (
    .clk    (CLK),
    .arst_n (ARST_N),
    .din    (PORT_IN),
    .dout   (pin_s)
  );

  // ****************************************
  // Transmit word buffer
  // ****************************************
  ssp_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (PWDATA[WORD_W-1:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st   = st;
    async_m   = st.mode[M_ASYNC];
    stop_m    = st.mode[M_STOP];
    // Only synchronised levels are used; edges rely on slow external clock
    tx_clk    = st.mode[M_SCK_OUT] ? st.sck_gen : pin_s[PIN_SCK];
    tx_fs     = st.mode[M_FS_OUT] ? st.fs_gen : pin_s[PIN_CTRL2];
    rx_clk    = async_m ? (st.mode[M_RXCLK_OUT] ? st.sck_gen : pin_s[PIN_CTRL0]) : tx_clk;
    rx_fs     = async_m ? (st.mode[M_RXFS_OUT] ? st.fs_gen : pin_s[PIN_CTRL1]) : tx_fs;
    tx_bit    = st.txsh[WORD_W-1];
    acc       = PSEL && PENABLE;
    tx_stall  = PWRITE && (PADDR == OFS_TXDATA) && !fifo_in_ready;
    fifo_push = acc && st.pready && PWRITE && (PADDR == OFS_TXDATA);
    fifo_pop  = 1'b0;

    // APB: answer registered, write lands on the edge that sees pready
    if (acc && st.pready)
    begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      if (PWRITE)
      begin
        unique case (PADDR)
          OFS_DIR:      next_st.dir      = PWDATA[NPINS-1:0];
          OFS_CTRL:     next_st.ctrl     = PWDATA[NPINS-1:0];
          OFS_MODE:     next_st.mode     = PWDATA[MODE_W-1:0];
          OFS_GPIO_OUT: next_st.gpio_out = PWDATA[NPINS-1:0];
          default:      next_st.pslverr  = 1'b0;
        endcase
      end
      else if (PADDR == OFS_RXDATA)
        next_st.rx_valid = 1'b0;
    end
    else if (acc && !tx_stall)
    begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !is_mapped(PADDR);
      next_st.prdata  = '0;
      if (!PWRITE)
      begin
        unique case (PADDR)
          OFS_DIR:      next_st.prdata[NPINS-1:0]  = st.dir;
          OFS_CTRL:     next_st.prdata[NPINS-1:0]  = st.ctrl;
          OFS_MODE:     next_st.prdata[MODE_W-1:0] = st.mode;
          OFS_GPIO_OUT: next_st.prdata[NPINS-1:0]  = st.gpio_out;
          OFS_GPIO_IN:  next_st.prdata[NPINS-1:0]  = st.gpio_in;
          OFS_RXDATA:   next_st.prdata[WORD_W-1:0] = st.rxword;
          OFS_STATUS:
          begin
            next_st.prdata[ST_TX_BUSY]    = (st.tx_state == TX_SHIFT);
            next_st.prdata[ST_RX_VALID]   = st.rx_valid;
            next_st.prdata[ST_FIFO_FULL]  = !fifo_in_ready;
            next_st.prdata[ST_FIFO_EMPTY] = !fifo_out_valid;
          end
          default:      next_st.prdata = '0;
        endcase
      end
    end

    // Serial role of each pin
    s_out[PIN_CTRL0]  = async_m ? st.sck_gen
                                : (st.mode[M_FLAG0_SEL] ? st.mode[M_FLAG0] : tx_bit);
    s_oe_n[PIN_CTRL0] = async_m ? !st.mode[M_RXCLK_OUT] : 1'b0;
    s_out[PIN_CTRL1]  = async_m ? st.fs_gen
                                : (st.mode[M_FLAG1_SEL] ? st.mode[M_FLAG1] : tx_bit);
    s_oe_n[PIN_CTRL1] = async_m ? !st.mode[M_RXFS_OUT] : 1'b0;
    s_out[PIN_CTRL2]  = st.fs_gen;
    s_oe_n[PIN_CTRL2] = !st.mode[M_FS_OUT];
    s_out[PIN_SCK]    = st.sck_gen;
    s_oe_n[PIN_SCK]   = !st.mode[M_SCK_OUT];
    s_out[PIN_RX]     = 1'b0;
    s_oe_n[PIN_RX]    = 1'b1;
    s_out[PIN_TX]     = tx_bit;
    s_oe_n[PIN_TX]    = (st.tx_state == TX_IDLE);

    // Stop freezes pins and inputs; wait bit has no effect here
    if (!stop_m)
    begin
      next_st.gpio_in    = pin_s;
      next_st.txclk_prev = tx_clk;
      next_st.rxclk_prev = rx_clk;
      for (int i = 0; i < NPINS; i++)
      begin
        next_st.port_out[i]  = st.ctrl[i] ? s_out[i] : st.gpio_out[i];
        next_st.port_oe_n[i] = st.ctrl[i] ? s_oe_n[i] : !st.dir[i];
      end

      // Bit clock divider
      if (st.div == SCK_HALF_LAST)
      begin
        next_st.div     = '0;
        next_st.sck_gen = !st.sck_gen;
      end
      else
        next_st.div = st.div + 1'b1;

      // Internal frame sync requests a word while idle with data waiting
      next_st.fs_gen = (st.tx_state == TX_IDLE) && fifo_out_valid;

      // Transmitter on rising bit clock
      if (edge_of(1'b0, 1'b1, st.txclk_prev, tx_clk))
      begin
        unique case (st.tx_state)
          TX_IDLE:
          begin
            if (tx_fs && fifo_out_valid)
            begin
              next_st.txsh     = fifo_out_data;
              next_st.txcnt    = '0;
              next_st.tx_state = TX_SHIFT;
              fifo_pop         = 1'b1;
            end
          end
          TX_SHIFT:
          begin
            if (st.txcnt == BIT_LAST)
            begin
              if (tx_fs && fifo_out_valid)
              begin
                next_st.txsh  = fifo_out_data;
                next_st.txcnt = '0;
                fifo_pop      = 1'b1;
              end
              else
                next_st.tx_state = TX_IDLE;
            end
            else
            begin
              next_st.txsh  = {st.txsh[WORD_W-2:0], 1'b0};
              next_st.txcnt = st.txcnt + 1'b1;
            end
          end
        endcase
      end

      // Receiver on falling bit clock; a new word beats a same-cycle clear
      if (edge_of(1'b1, 1'b0, st.rxclk_prev, rx_clk) && (st.rx_act || rx_fs))
      begin
        next_st.rxsh   = {st.rxsh[WORD_W-2:0], pin_s[PIN_RX]};
        next_st.rxcnt  = st.rxcnt + 1'b1;
        next_st.rx_act = 1'b1;
        if (st.rxcnt == BIT_LAST)
        begin
          next_st.rxword   = {st.rxsh[WORD_W-2:0], pin_s[PIN_RX]};
          next_st.rx_valid = 1'b1;
          next_st.rx_act   = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      st <= ST_RST;
    else
      st <= next_st;
  end

  assign PRDATA    = st.prdata;
  assign PREADY    = st.pready;
  assign PSLVERR   = st.pslverr;
  assign PORT_OUT  = st.port_out;
  assign PORT_OE_N = st.port_oe_n;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  reset_gpio_in_a: assert property ($rose(ARST_N) |-> (PORT_OE_N == '1) && (st.ctrl == '0))
    else $error("Pins not general inputs after reset");

  gpio_direction_a: assert property (!stop_m |=>
    (((PORT_OE_N ^ ~$past(st.dir)) & ~$past(st.ctrl)) == '0))
    else $error("General pin direction differs from direction register");

  serial_select_a: assert property (st.ctrl[PIN_RX] && !stop_m |=> PORT_OE_N[PIN_RX])
    else $error("Receive pin driven in serial mode");

  async_rxclk_a: assert property (st.ctrl[0] && async_m && st.mode[M_RXCLK_OUT] && !stop_m
    |=> !PORT_OE_N[0] && (PORT_OUT[0] == $past(st.sck_gen)))
    else $error("Receive clock not driven on control pin zero");

  sync_pin_zero_a: assert property (st.ctrl[0] && !async_m && !stop_m
    |=> !PORT_OE_N[0] && (PORT_OUT[0] ==
        ($past(st.mode[M_FLAG0_SEL]) ? $past(st.mode[M_FLAG0]) : $past(tx_bit))))
    else $error("Control pin zero wrong in synchronous mode");

  async_rxfs_in_a: assert property (st.ctrl[1] && async_m && !st.mode[M_RXFS_OUT] && !stop_m
    |=> PORT_OE_N[1])
    else $error("Receive frame sync input is driven");

  sync_pin_one_a: assert property (st.ctrl[1] && !async_m && !stop_m
    |=> !PORT_OE_N[1] && (PORT_OUT[1] ==
        ($past(st.mode[M_FLAG1_SEL]) ? $past(st.mode[M_FLAG1]) : $past(tx_bit))))
    else $error("Control pin one wrong in synchronous mode");

  frame_sync_out_a: assert property (st.ctrl[2] && st.mode[M_FS_OUT] && !stop_m
    |=> !PORT_OE_N[2] && (PORT_OUT[2] == $past(st.fs_gen)))
    else $error("Internal frame sync not driven");

  bit_clock_pin_a: assert property (st.ctrl[3] && !stop_m
    |=> (PORT_OE_N[3] == !$past(st.mode[M_SCK_OUT])))
    else $error("Bit clock pin direction wrong");

  tx_drive_a: assert property (st.ctrl[5] && (st.tx_state == TX_SHIFT) && !stop_m
    |=> !PORT_OE_N[5] && (PORT_OUT[5] == $past(tx_bit)))
    else $error("Transmit pin not driven while busy");

  stop_hold_a: assert property (stop_m |=> $stable(PORT_OUT) && $stable(PORT_OE_N)
    && $stable(st.gpio_in))
    else $error("Pins changed in stop state");

endmodule

// [bench/ssp_far_end.sv]
// Purpose: Far-side serial peer for the shared pins
// Assumes: No pull resistors on the pins
// Notes:   Link clock stands still outside frames
module ssp_far_end
  import ssp_pkg::*;
(
  input  wire logic [NPINS-1:0] out,
  input  wire logic [NPINS-1:0] oe_n,
  input  wire logic [NPINS-1:0] level,
  input  wire logic             go,
  input  wire logic [7:0]       tx_byte,
  output wire logic [NPINS-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;

  logic             sck    = 1'b0;
  logic             fs     = 1'b0;
  logic             sd     = 1'b0;
  logic             active = 1'b0;
  logic [NPINS-1:0] far;

  // Peer drives only pins that the block leaves undriven
  assign far  = active ? {level[5], sd, sck, fs, level[1:0]} : level;
  assign pins = (out & ~oe_n) | (far & oe_n);

  // One frame, sync with first bit, MSB first
  always @(posedge go)
  begin
    active = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      fs  = (i == 0);
      sd  = tx_byte[7-i];
      sck = 1'b1;
      #160;
      sck = 1'b0;
      #160;
    end
    fs     = 1'b0;
    sd     = ~sd;
    active = 1'b0;
  end
endmodule

// [bench/tb_ssp_pin_roles.sv]
// Purpose: Self-checking bench for the pin role block
// Assumes: APB master in this bench, peer model on the pins
// Notes:   Reads and serial bits are checked against queued notes
module tb_ssp_pin_roles
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} rd_exp_t;

  logic             clk       = 1'b0;
  logic             arst_n    = 1'b0;
  logic             psel      = 1'b0;
  logic             penable   = 1'b0;
  logic             pwrite    = 1'b0;
  logic [AW-1:0]    paddr     = '0;
  logic [31:0]      pwdata    = '0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [NPINS-1:0] port_in;
  logic [NPINS-1:0] port_out;
  logic [NPINS-1:0] port_oe_n;
  logic [NPINS-1:0] level     = '0;
  logic             go        = 1'b0;
  logic [7:0]       tx_byte   = '0;
  logic             sck_prev  = 1'b0;
  logic [5:0]       dv, ov, lv;
  logic [7:0]       b;
  int               seed, n;
  int               miscompares = 0;
  int               num_checks  = 0;
  rd_exp_t          rq [$];
  rd_exp_t          e;
  logic             bq [$];
  logic [AW-1:0]    regs [4]  = '{OFS_DIR, OFS_CTRL, OFS_MODE, OFS_GPIO_OUT};
  logic [10:0]      modes [6] = '{11'h000, 11'h010, 11'h001, 11'h061, 11'h021, 11'h186};
  logic [2:0]       oes [6]   = '{3'h4, 3'h0, 3'h7, 3'h4, 3'h6, 3'h4};

  always #20 clk = ~clk;

  ssp_pin_roles u_ssp_pin_roles (
    .CLK       (clk),
    .ARST_N    (arst_n),
    .PSEL      (psel),
    .PENABLE   (penable),
    .PWRITE    (pwrite),
    .PADDR     (paddr),
    .PWDATA    (pwdata),
    .PRDATA    (prdata),
    .PREADY    (pready),
    .PSLVERR   (pslverr),
    .PORT_IN   (port_in),
    .PORT_OUT  (port_out),
    .PORT_OE_N (port_oe_n)
  );

  ssp_far_end u_ssp_far_end (
    .out     (port_out),
    .oe_n    (port_oe_n),
    .level   (level),
    .go      (go),
    .tx_byte (tx_byte),
    .pins    (port_in)
  );

  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Hold the request until pready is seen high at a rising edge
    do
      @(posedge clk);
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic err);
    rq.push_back('{d, m, err});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  // Read answers against the oldest note
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite && rq.size() != 0)
    begin
      e = rq.pop_front();
      chk(prdata & e.m, e.d & e.m, "read data");
      chk({31'h0, pslverr}, {31'h0, e.e}, "read err");
    end

  // Transmit bit taken at each falling bit clock
  always @(posedge clk)
  begin
    if (sck_prev && !port_out[PIN_SCK] && port_oe_n[PIN_SCK] === 1'b0
        && port_oe_n[PIN_TX] === 1'b0)
    begin
      if (bq.size() == 0)
        chk(32'h1, 32'h0, "extra bit");
      else
        chk({31'h0, port_out[PIN_TX]}, {31'h0, bq.pop_front()}, "tx bit");
    end
    sck_prev <= port_out[PIN_SCK];
  end

  initial
  begin
    #400000;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end

  initial
  begin
    seed = 32'h84d0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk({26'h0, port_oe_n}, 32'h3f, "reset oe");
    foreach (regs[i])
      rd(regs[i], 32'h0, 32'hffffffff, 1'b0);
    rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
    repeat (4)
    begin
      dv = 6'($random(seed));
      ov = 6'($random(seed));
      lv = 6'($random(seed));
      wr(OFS_DIR, {26'h0, dv});
      level <= lv;
      wr(OFS_GPIO_OUT, {26'h0, ov});
      settle();
      chk({26'h0, port_oe_n}, {26'h0, ~dv}, "gpio dir");
      chk({26'h0, port_out}, {26'h0, ov}, "gpio out");
      rd(OFS_GPIO_IN, {26'h0, (ov & dv) | (lv & ~dv)}, 32'h3f, 1'b0);
    end
    wr(OFS_DIR, 32'h0);
    wr(OFS_CTRL, 32'h07);
    foreach (modes[i])
    begin
      wr(OFS_MODE, {21'h0, modes[i]});
      settle();
      chk({29'h0, port_oe_n[2:0]}, {29'h0, oes[i]}, "role oe");
    end
    chk({30'h0, port_out[1:0]}, 32'h3, "flags");
    wr(OFS_CTRL, 32'h38);
    wr(OFS_DIR, 32'h03);
    wr(OFS_GPIO_OUT, 32'h01);
    wr(OFS_MODE, 32'h018);
    wr(OFS_MODE, 32'h218);
    wr(OFS_GPIO_OUT, 32'h02);
    settle();
    chk({26'h0, port_oe_n}, 32'h34, "stop oe");
    chk({30'h0, port_out[1:0]}, 32'h1, "stop level");
    repeat (FIFO_DEPTH)
    begin
      b = 8'($random(seed));
      for (int k = 7; k >= 0; k--)
        bq.push_back(b[k]);
      wr(OFS_TXDATA, {24'h0, b});
    end
    rd(OFS_STATUS, 32'h4, 32'hc, 1'b0);
    wr(OFS_MODE, 32'h018);
    n = 0;
    while (bq.size() != 0 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(bq.size()), 32'h0, "tx drained");
    repeat (12) @(negedge clk);
    rd(OFS_STATUS, 32'h8, 32'h9, 1'b0);
    wr(OFS_MODE, 32'h418);
    settle();
    chk({26'h0, port_oe_n}, 32'h34, "wait oe");
    chk({30'h0, port_out[1:0]}, 32'h2, "wait level");
    b = 8'($random(seed));
    tx_byte <= b;
    wr(OFS_CTRL, 32'h1c);
    wr(OFS_MODE, 32'h000);
    go <= 1'b1;
    repeat (100) @(posedge clk);
    go <= 1'b0;
    rd(OFS_RXDATA, {24'h0, b}, 32'hff, 1'b0);
    summarize();
  end
endmodule
